/* File: logic/exi_pkg.sv */
`default_nettype none

package exi_pkg;

    // number of external interrupt inputs handled here
    localparam int EXI_NUM = 5;

    // bit positions of the inputs inside every five-bit vector
    localparam int EXI_POS_ZERO = 0;
    localparam int EXI_POS_ONE = 1;
    localparam int EXI_POS_TWO = 2;
    localparam int EXI_POS_THREE = 3;
    localparam int EXI_POS_FOUR = 4;

    // pins idle high, so the sampled levels reset high and no edge is seen at release
    localparam logic [4:0] EXI_LEVEL_RESET = 5'h1F;
    localparam logic [4:0] EXI_FLAG_RESET = 5'h00;
    localparam logic [2:0] EXI_INDEX_RESET = 3'h0;
    localparam logic [2:0] EXI_INDEX_LAST = 3'h4;
    localparam logic EXI_BIT_RESET = 1'b0;

    // inputs one to four may end power-down
    localparam logic [4:0] EXI_WAKE_CAPABLE = 5'h1E;
    // only inputs zero and one own a trigger-select bit
    localparam logic [4:0] EXI_SELECTABLE = 5'h03;
    // one-hot seed for decoding an acknowledged index
    localparam logic [4:0] EXI_ONE_HOT_BASE = 5'h01;

    // power sequencing states, one-hot
    typedef enum logic [2:0] {
        EXI_RUN = 3'h1,
        EXI_SLEEP = 3'h2,
        EXI_WAKE = 3'h4
    } exi_power_t;

    // static control levels from the core
    typedef struct packed {
        logic [4:0] enable;
        logic global_enable;
        logic trigger_select_zero;
        logic trigger_select_one;
        logic power_down;
    } exi_ctrl_t;

    // service strobes from the core
    typedef struct packed {
        logic [4:0] clear;
        logic ack;
    } exi_service_t;

    // everything the block reports
    typedef struct packed {
        logic [4:0] level;
        logic [4:0] edge_event;
        logic [4:0] pending;
        logic [4:0] overrun;
        logic request;
        logic [2:0] index;
        logic wake;
        logic asleep;
    } exi_status_t;

    typedef struct packed {
        logic [4:0] first;
        logic [4:0] second;
    } exi_sync_state_t;

    typedef struct packed {
        logic [4:0] prev;
        logic [4:0] pulse;
    } exi_detect_state_t;

    typedef struct packed {
        exi_power_t power;
        logic [4:0] pending;
        logic [4:0] overrun;
        logic [4:0] edge_event;
        logic request;
        logic [2:0] index;
        logic wake;
    } exi_state_t;

endpackage

`default_nettype wire

/* File: logic/exi_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module exi_sync
    import exi_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // raw pins
    input wire logic [4:0] i_pin,
    // synchronised levels
    output logic [4:0] o_level
);

    exi_sync_state_t state;
    exi_sync_state_t next_state;

    // the first stage feeds only the second stage, to let metastability settle
    always_comb
    begin
        next_state = state;
        next_state.first = i_pin;
        next_state.second = state.first;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state.first <= EXI_LEVEL_RESET;
            state.second <= EXI_LEVEL_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_level = state.second;

endmodule

`default_nettype wire

/* File: logic/exi_detect.sv */
`timescale 1ns/1ns
`default_nettype none

module exi_detect
    import exi_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // synchronised levels and per-input edge mode
    input wire logic [4:0] i_level,
    input wire logic [4:0] i_both,
    // one-cycle qualifying edge pulses
    output logic [4:0] o_pulse
);

    exi_detect_state_t state;
    exi_detect_state_t next_state;
    logic [4:0] fall;
    logic [4:0] rise;
    logic [4:0] hit;

    // a falling edge always qualifies; a rising one only in both-edge mode
    for (genvar g = 0; g < EXI_NUM; g++)
    begin : g_bit
        assign fall[g] = state.prev[g] & ~i_level[g];
        assign rise[g] = ~state.prev[g] & i_level[g];
        assign hit[g] = fall[g] | (i_both[g] & rise[g]);
    end

    always_comb
    begin
        next_state = state;
        next_state.prev = i_level;
        next_state.pulse = hit;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state.prev <= EXI_LEVEL_RESET;
            state.pulse <= EXI_FLAG_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_pulse = state.pulse;

endmodule

`default_nettype wire

/* File: logic/exi_edge_detect.sv */
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Select bit zero at 1: input zero requests only on falling edges.
// - Select bit zero at 0: input zero requests on rising and falling edges.
// - Select bit one at 1: input one requests only on falling edges.
// - Select bit one at 0: input one requests on rising and falling edges.
// - An enabled interrupt on input one wakes the device from power-down.
// - Input two has no select bit and requests on falling edges only.
// - Input three has no select bit and requests on falling edges only.
// - An enabled interrupt on input three wakes the device from power-down.
// - Input four has no select bit and requests on falling edges only.
// - An enabled interrupt on input four wakes the device from power-down.
module exi_edge_detect
    import exi_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // interrupt pins, asynchronous to the system clock
    input wire logic i_ext_irq_in_zero,
    input wire logic i_ext_irq_in_one,
    input wire logic i_ext_irq_in_two,
    input wire logic i_ext_irq_in_three,
    input wire logic i_ext_irq_in_four,
    // control levels and service strobes from the core
    input wire exi_ctrl_t i_ctrl,
    input wire exi_service_t i_service,
    // status toward the core
    output exi_status_t o_status
);

    // gathered pins, lowest index is input zero
    logic [4:0] pins;
    // synchronised pin levels
    logic [4:0] level;
    // per-input both-edge mode
    logic [4:0] both;
    // one-cycle qualifying edge pulses
    logic [4:0] detect;
    // mask of flags cleared this cycle
    logic [4:0] clear_mask;
    // decoded acknowledge of the granted input
    logic [4:0] ack_mask;
    // flags that may be granted after this cycle
    logic [4:0] armed;
    // enabled flags able to end power-down
    logic [4:0] wake_source;
    // winning index of the priority search
    logic [2:0] grant;
    logic found;

    exi_state_t state;
    exi_state_t next_state;

    assign pins[EXI_POS_ZERO] = i_ext_irq_in_zero;
    assign pins[EXI_POS_ONE] = i_ext_irq_in_one;
    assign pins[EXI_POS_TWO] = i_ext_irq_in_two;
    assign pins[EXI_POS_THREE] = i_ext_irq_in_three;
    assign pins[EXI_POS_FOUR] = i_ext_irq_in_four;

    // two flops per pin before anything looks at the level
    exi_sync u_sync
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_pin(pins),
        .o_level(level)
    );

    // edge mode per input; inputs without a select bit stay falling-only
    always_comb
    begin
        both = EXI_FLAG_RESET;
        both[EXI_POS_ZERO] = ~i_ctrl.trigger_select_zero;
        both[EXI_POS_ONE] = ~i_ctrl.trigger_select_one;
        both[EXI_POS_TWO] = 1'b0;
        both[EXI_POS_THREE] = 1'b0;
        both[EXI_POS_FOUR] = 1'b0;
        both = both & EXI_SELECTABLE;
    end

    // edge detection on the synchronised levels
    exi_detect u_detect
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_level(level),
        .i_both(both),
        .o_pulse(detect)
    );

    // an acknowledge clears only the input that was actually granted
    always_comb
    begin
        ack_mask = EXI_FLAG_RESET;
        if (i_service.ack && state.request)
        begin
            ack_mask = EXI_ONE_HOT_BASE << state.index;
        end
    end

    assign clear_mask = i_service.clear | ack_mask;

    // wake only from inputs that are enabled and wake-capable
    assign wake_source = state.pending & i_ctrl.enable & EXI_WAKE_CAPABLE
        & {EXI_NUM{i_ctrl.global_enable}};

    // flag update, priority search and power sequencing
    always_comb
    begin
        next_state = state;
        grant = EXI_INDEX_RESET;
        found = 1'b0;

        // pulses are re-registered so the core sees them beside the flags
        next_state.edge_event = detect;

        // a new edge beats a clear in the same cycle, so no event is lost
        next_state.pending = (state.pending & ~clear_mask) | detect;

        // an edge landing on a flag still set is recorded as an overrun
        next_state.overrun = (state.overrun & ~i_service.clear)
            | (detect & state.pending);

        // request follows the updated flags so an acknowledge drops it at once
        armed = next_state.pending & i_ctrl.enable
            & {EXI_NUM{i_ctrl.global_enable}};

        // fixed priority, input zero highest; search from the top down
        for (int i = EXI_NUM - 1; i >= 0; i--)
        begin
            if (armed[i])
            begin
                grant = i[2:0];
                found = 1'b1;
            end
        end
        next_state.request = found;
        next_state.index = found ? grant : state.index;

        // power-down sequencing; the system clock is assumed to keep running
        // here, the clock gating itself sits outside this block
        case (state.power)
            EXI_RUN:
            begin
                next_state.wake = 1'b0;
                if (i_ctrl.power_down)
                begin
                    next_state.power = EXI_SLEEP;
                end
            end
            EXI_SLEEP:
            begin
                if (!i_ctrl.power_down)
                begin
                    next_state.power = EXI_RUN;
                end
                else if (|wake_source)
                begin
                    // hold wake until the core leaves power-down
                    next_state.power = EXI_WAKE;
                    next_state.wake = 1'b1;
                end
            end
            EXI_WAKE:
            begin
                if (!i_ctrl.power_down)
                begin
                    next_state.power = EXI_RUN;
                    next_state.wake = 1'b0;
                end
            end
            default:
            begin
                // an illegal code falls back to run, never stuck asleep
                next_state.power = EXI_RUN;
                next_state.wake = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state.power <= EXI_RUN;
            state.pending <= EXI_FLAG_RESET;
            state.overrun <= EXI_FLAG_RESET;
            state.edge_event <= EXI_FLAG_RESET;
            state.request <= EXI_BIT_RESET;
            state.index <= EXI_INDEX_RESET;
            state.wake <= EXI_BIT_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // status fields come straight from flops, except asleep, which is decoded from the power state
    always_comb
    begin
        o_status.level = level;
        o_status.edge_event = state.edge_event;
        o_status.pending = state.pending;
        o_status.overrun = state.overrun;
        o_status.request = state.request;
        o_status.index = state.index;
        o_status.wake = state.wake;
        o_status.asleep = (state.power != EXI_RUN);
    end

endmodule

`default_nettype wire

/* File: tb/exi_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none

module exi_pin_model
(
    // clock
    input wire logic i_clk_sys,
    // level each pin should settle at
    input wire logic [4:0] i_want,
    // pin levels, pulled high while idle
    output logic [4:0] o_pin
);
    // pins move only on the falling edge so no sample lands on a transition
    always @(negedge i_clk_sys)
    begin
        o_pin <= i_want;
    end
    initial o_pin = 5'h1F;
endmodule

`default_nettype wire

/* File: tb/exi_edge_monitor.sv */
`timescale 1ns/1ns
`default_nettype none

module exi_edge_monitor
    import exi_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // watched pin and core side
    input wire logic i_ext_irq_in_three,
    input wire exi_ctrl_t i_ctrl,
    input wire exi_service_t i_service,
    input wire exi_status_t o_status
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // edge seen two edges after the synchronised level moves
    sync_lvl_a: assert property ($fell(i_ext_irq_in_three) |-> ##2 !o_status.level[3])
        else $error("level lags pin");
    zero_fall_a: assert property ($fell(o_status.level[0]) |-> ##2 o_status.edge_event[0])
        else $error("input zero fall missed");
    zero_both_a: assert property ($rose(o_status.level[0]) && !i_ctrl.trigger_select_zero
        |-> ##2 o_status.edge_event[0])
        else $error("input zero rise missed");
    zero_sel_a: assert property (o_status.edge_event[0] && i_ctrl.trigger_select_zero
        |-> !$past(o_status.level[0], 2))
        else $error("input zero rise taken");
    one_both_a: assert property ($rose(o_status.level[1]) && !i_ctrl.trigger_select_one
        |-> ##2 o_status.edge_event[1])
        else $error("input one rise missed");
    one_sel_a: assert property (o_status.edge_event[1] && i_ctrl.trigger_select_one
        |-> !$past(o_status.level[1], 2))
        else $error("input one rise taken");
    // inputs two to four never react to a rising level
    fixed_fall_a: assert property ((o_status.edge_event & $past(o_status.level, 2) & 5'h1C)
        == 5'h00)
        else $error("fixed input rise taken");
    pend_set_a: assert property ((o_status.edge_event & ~o_status.pending) == 5'h00)
        else $error("event without pending");
    pend_hold_a: assert property (i_service.clear == 5'h00 && !i_service.ack
        |=> ($past(o_status.pending) & ~o_status.pending) == 5'h00)
        else $error("pending lost");
    wake_up_a: assert property (o_status.asleep && i_ctrl.power_down && i_ctrl.global_enable
        && (o_status.pending & i_ctrl.enable & 5'h1E) != 5'h00
        |-> ##[0:2] o_status.wake)
        else $error("no wake");

    cover property (o_status.wake);
    cover property (i_service.ack && o_status.request);
    cover property ($rose(o_status.level[0]) ##2 o_status.edge_event[0]);
endmodule

bind exi_edge_detect exi_edge_monitor i_exi_edge_monitor (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ext_irq_in_three(i_ext_irq_in_three),
    .i_ctrl(i_ctrl),
    .i_service(i_service),
    .o_status(o_status)
);

`default_nettype wire

/* File: tb/exi_edge_detect_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module exi_edge_detect_bench
    import exi_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [4:0] want;
    logic [4:0] pin;
    exi_ctrl_t ctrl;
    exi_service_t svc;
    exi_status_t st;
    int fails = 0;
    int samples_checked = 0;

    always #50 i_clk_sys = ~i_clk_sys;

    exi_pin_model i_exi_pin_model (
        .i_clk_sys(i_clk_sys),
        .i_want(want),
        .o_pin(pin)
    );

    exi_edge_detect i_exi_edge_detect (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ext_irq_in_zero(pin[0]),
        .i_ext_irq_in_one(pin[1]),
        .i_ext_irq_in_two(pin[2]),
        .i_ext_irq_in_three(pin[3]),
        .i_ext_irq_in_four(pin[4]),
        .i_ctrl(ctrl),
        .i_service(svc),
        .o_status(st)
    );

    task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // window covers the four-edge latency plus the model's one-cycle lag
    task automatic drive(input int i, input logic v, output logic [4:0] ev);
        ev = 5'h00;
        @(negedge i_clk_sys);
        want[i] <= v;
        repeat (8)
        begin
            @(negedge i_clk_sys);
            ev = ev | st.edge_event;
        end
    endtask

    task automatic clr;
        @(negedge i_clk_sys);
        svc.clear <= 5'h1F;
        @(negedge i_clk_sys);
        svc.clear <= 5'h00;
    endtask

    // every input, both select settings, both directions
    task automatic s_modes;
        logic [4:0] ev;
        for (int s = 0; s < 2; s++)
        begin
            ctrl.trigger_select_zero <= s[0];
            ctrl.trigger_select_one <= s[0];
            for (int i = 0; i < 5; i++)
            begin
                drive(i, 1'b0, ev);
                check("fall_ev", ev, 5'h01 << i);
                check("fall_pend", st.pending, 5'h01 << i);
                check("fall_lvl", st.level, 5'h1F & ~(5'h01 << i));
                drive(i, 1'b1, ev);
                check("rise_ev", ev, (i < 2 && s == 0) ? 5'h01 << i : 5'h00);
                // a second edge on a still-pending flag must show as an overrun
                check("rise_ovr", st.overrun, (i < 2 && s == 0) ? 5'h01 << i : 5'h00);
                clr();
            end
        end
    endtask

    // flag must outlive the edge by far, then go on acknowledge
    task automatic s_hold;
        logic [4:0] ev;
        drive(2, 1'b0, ev);
        repeat (20) @(negedge i_clk_sys);
        check("held", st.pending, 5'h04);
        check("index", {2'h0, st.index}, 5'h02);
        svc.ack <= 1'b1;
        @(negedge i_clk_sys);
        svc.ack <= 1'b0;
        @(negedge i_clk_sys);
        check("acked", {st.pending[4:1], st.request}, 5'h00);
        drive(2, 1'b1, ev);
    endtask

    // input zero is not wake-capable, so it must leave the core asleep
    task automatic s_wake;
        logic [4:0] ev;
        ctrl.trigger_select_zero <= 1'b1;
        ctrl.trigger_select_one <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            @(negedge i_clk_sys);
            ctrl.power_down <= 1'b1;
            drive(i, 1'b0, ev);
            check("asleep", {4'h0, st.asleep}, 5'h01);
            check("wake", {4'h0, st.wake}, (i != 0) ? 5'h01 : 5'h00);
            ctrl.power_down <= 1'b0;
            drive(i, 1'b1, ev);
            check("woken", {3'h0, st.wake, st.asleep}, 5'h00);
            clr();
        end
    endtask

    initial
    begin
        want = 5'h1F;
        ctrl = '0;
        ctrl.enable = 5'h1F;
        ctrl.global_enable = 1'b1;
        svc = '0;
        repeat (3) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        s_modes();
        s_hold();
        s_wake();
        end_sim();
    end

    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        fails++;
        end_sim();
    end
endmodule

`default_nettype wire
